// ---- core/psel_consts.svh ----
// constants for the parameter set priority selector
`ifndef PSEL_CONSTS_SVH
`define PSEL_CONSTS_SVH
`define PSEL_NSETS 8
`define PSEL_IDXW 3
`define PSEL_ACTIVE_RST 3'h0
`define PSEL_USED_RST 3'h0
`define PSEL_TS_W 32
`define PSEL_CODE_W 6
`define PSEL_STABLE_CYC 2
`define PSEL_EV_ENABLED 6'h00
`define PSEL_EV_REQ 6'h08
`define PSEL_EV_REMOTE 6'h10
`define PSEL_EV_LOCAL 6'h11
`define PSEL_EV_FORCE 6'h12
`define PSEL_EV_FAIL_NCFG 6'h13
`define PSEL_EV_FAIL_FORCE 6'h14
`define PSEL_EV_FAIL_PRIO 6'h15
`define PSEL_EV_ACTIVE 6'h18
`define PSEL_EV_COUNT 32
`endif

// ---- core/psel_pkg.sv ----
// types for the parameter set priority selector
package psel_pkg;
  typedef struct packed {
    logic [5:0] code;
    logic on;
    logic [31:0] stamp;
  } psel_event_t;
  typedef struct packed {
    logic force_en;
    logic [3:0] force_set;
    logic [3:0] remote_set;
    logic [3:0] local_set;
    logic [2:0] used_sets;
  } psel_cfg_t;
  typedef enum logic [2:0] {
    PSEL_IDLE = 3'b001,
    PSEL_RUN = 3'b010,
    PSEL_FORCED = 3'b100
  } psel_state_t;
endpackage : psel_pkg

// ---- core/psel_edge_det.sv ----
// one status bit: edge detect and on/off store filter
`timescale 1ns/1ps
module psel_edge_det (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic level,
  input wire logic store_on,
  input wire logic store_off,
  output logic rise,
  output logic fall
);
  logic prev_q;
  logic prev_d;
  logic armed_q;
  logic armed_d;
  always_comb begin
    prev_d = level;
    armed_d = 1'b1;
  end
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      prev_q <= 1'b0;
      armed_q <= 1'b0;
    end else begin
      prev_q <= prev_d;
      armed_q <= armed_d;
    end
  end
  // first cycle after reset only loads the level: reset values of the
  // watched status are not edges
  // edge is only reported when its direction is selected for storage
  assign rise = armed_q & level & ~prev_q & store_on;
  assign fall = armed_q & ~level & prev_q & store_off;
endmodule : psel_edge_det

// ---- core/psel_selector.sv ----
// parameter set priority selector with time-stamped event output
//
// Behaviour
// RQ1 - eight requests, set one highest priority
// RQ2 - requests work as pulses or levels
// RQ3 - held set one request blocks all others
// RQ4 - held request n blocks lower inputs
// RQ5 - held set eight request blocks nothing
// RQ6 - selection stays after request removed
// RQ7 - every event carries a time stamp
// RQ8 - per event store on, off or both
// RQ9 - remote, local, force events on and off
// RQ10 - unconfigured set request rejected, fail event
// RQ11 - force fail and priority fail events
// RQ12 - pulse selected set kept until another
// RQ13 - forcing overrides inputs until disabled
// RQ14 - reset: only set one, selector idle
// RQ15 - three bit active index, active events
`timescale 1ns/1ps
`include "psel_consts.svh"
module psel_selector
  import psel_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic [7:0] param_set_request,
  input wire psel_cfg_t cfg,
  input wire logic [`PSEL_EV_COUNT-1:0] store_on,
  input wire logic [`PSEL_EV_COUNT-1:0] store_off,
  output logic [2:0] active_set_q,
  output logic [7:0] set_enabled_q,
  output logic event_valid_q,
  output psel_event_t event_q
);
  // request pins come from outside: two flops first
  logic [7:0] req_s1_q;
  logic [7:0] req_s2_q;
  logic [7:0] req_prev_q;
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      req_s1_q <= 8'h00;
      req_s2_q <= 8'h00;
      req_prev_q <= 8'h00;
    end else begin
      req_s1_q <= param_set_request;
      req_s2_q <= req_s1_q;
      req_prev_q <= req_s2_q;
    end
  end

  // time stamp counter
  logic [`PSEL_TS_W-1:0] ts_q;
  logic [`PSEL_TS_W-1:0] ts_d;
  always_comb begin
    ts_d = ts_q + `PSEL_TS_W'(1);
  end
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      ts_q <= '0;
    end else begin
      ts_q <= ts_d;
    end
  end

  // a new request is a rising edge; a held level is one standing high
  logic [7:0] req_new;
  logic [7:0] req_held;
  logic [7:0] enabled;
  assign req_new = req_s2_q & ~req_prev_q; // [RQ2]
  assign req_held = req_s2_q & req_prev_q; // [RQ2]
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      enabled[i] = (3'(i) <= cfg.used_sets);
    end
  end

  psel_state_t st_q;
  psel_state_t st_d;
  logic [2:0] act_d;
  logic fail_ncfg;
  logic fail_prio;
  logic fail_force;
  logic remote_req;
  logic local_req;

  always_comb begin
    logic found;
    logic blocked;
    logic won_new;
    logic [2:0] blk_idx;
    logic [2:0] rl_idx;
    found = 1'b0;
    blocked = 1'b0;
    won_new = 1'b0;
    blk_idx = 3'h7;
    rl_idx = 3'h0;
    act_d = active_set_q;
    st_d = st_q;
    fail_ncfg = 1'b0;
    fail_prio = 1'b0;
    fail_force = 1'b0;
    remote_req = cfg.remote_set != 4'h0;
    local_req = cfg.local_set != 4'h0;
    case (st_q)
      PSEL_IDLE: begin
        act_d = 3'h0; // [RQ14]
        if (cfg.force_en) begin
          st_d = PSEL_FORCED;
        end else if (cfg.used_sets != 3'h0) begin
          st_d = PSEL_RUN;
        end
      end
      PSEL_RUN: begin
        // index 0 first: set one wins ties [RQ1]
        for (int i = 0; i < 8; i++) begin
          if (blocked && req_new[i]) begin
            fail_prio = 1'b1; // [RQ11]
          end else if (!found && !blocked
              && (req_new[i] || req_held[i])) begin
            if (!enabled[i]) begin
              fail_ncfg = 1'b1; // [RQ10]
            end else begin
              found = 1'b1;
              won_new = req_new[i];
              act_d = 3'(i);
            end
          end
          // a held level stops all lower inputs, but set eight has none
          if (req_held[i] && i < 7 && !blocked) begin
            blocked = 1'b1; // [RQ3] [RQ4] [RQ5]
            blk_idx = 3'(i);
          end
        end
        // remote beats local; a fresh pin request wins this cycle, a held
        // one only refuses a change to a lower priority set
        rl_idx = remote_req ? cfg.remote_set[2:0] - 3'h1
                            : cfg.local_set[2:0] - 3'h1;
        if (!won_new && (remote_req || local_req)) begin
          if (!enabled[rl_idx]) begin
            fail_ncfg = 1'b1; // [RQ10]
          end else if (blocked && rl_idx > blk_idx) begin
            fail_prio = 1'b1; // [RQ11]
          end else begin
            act_d = rl_idx;
          end
        end
        // no request: keep current set, no fall back [RQ6] [RQ12]
        if (cfg.force_en) begin
          st_d = PSEL_FORCED;
        end else if (cfg.used_sets == 3'h0) begin
          st_d = PSEL_IDLE;
          act_d = 3'h0;
        end
      end
      PSEL_FORCED: begin
        // inputs ignored, operator choice only [RQ13]
        if (cfg.force_set != 4'h0) begin
          if (enabled[cfg.force_set[2:0] - 3'h1]) begin
            act_d = cfg.force_set[2:0] - 3'h1;
          end else begin
            fail_force = 1'b1; // [RQ11]
          end
        end
        if (!cfg.force_en) begin
          st_d = (cfg.used_sets == 3'h0) ? PSEL_IDLE : PSEL_RUN;
        end
      end
      default: begin
        st_d = PSEL_IDLE;
        act_d = 3'h0;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      st_q <= PSEL_IDLE;
      active_set_q <= `PSEL_ACTIVE_RST; // [RQ14]
      set_enabled_q <= 8'h01;
    end else begin
      st_q <= st_d;
      active_set_q <= act_d; // [RQ15]
      set_enabled_q <= enabled;
    end
  end

  // status levels watched for events
  logic [`PSEL_EV_COUNT-1:0] ev_level;
  logic [`PSEL_EV_COUNT-1:0] ev_rise;
  logic [`PSEL_EV_COUNT-1:0] ev_fall;
  always_comb begin
    ev_level = '0;
    ev_level[7:0] = set_enabled_q;
    ev_level[15:8] = req_s2_q;
    ev_level[16] = remote_req; // [RQ9]
    ev_level[17] = local_req; // [RQ9]
    ev_level[18] = cfg.force_en; // [RQ9]
    ev_level[19] = fail_ncfg; // [RQ10]
    ev_level[20] = fail_force; // [RQ11]
    ev_level[21] = fail_prio; // [RQ11]
    for (int i = 0; i < 8; i++) begin
      ev_level[24+i] = (active_set_q == 3'(i)); // [RQ15]
    end
  end

  for (genvar g = 0; g < `PSEL_EV_COUNT; g++) begin : g_ev
    psel_edge_det u_edge (
      .sys_clk(sys_clk),
      .rstn(rstn),
      .level(ev_level[g]),
      .store_on(store_on[g]), // [RQ8]
      .store_off(store_off[g]), // [RQ8]
      .rise(ev_rise[g]),
      .fall(ev_fall[g])
    );
  end

  // pending edges, reported one per cycle, lowest index first
  logic [`PSEL_EV_COUNT-1:0] pend_on_q;
  logic [`PSEL_EV_COUNT-1:0] pend_off_q;
  logic [`PSEL_EV_COUNT-1:0] pend_on_d;
  logic [`PSEL_EV_COUNT-1:0] pend_off_d;
  logic ev_valid_d;
  psel_event_t ev_d;
  always_comb begin
    logic done;
    done = 1'b0;
    pend_on_d = pend_on_q;
    pend_off_d = pend_off_q;
    ev_valid_d = 1'b0;
    ev_d = event_q;
    for (int i = 0; i < `PSEL_EV_COUNT; i++) begin
      if (!done && (pend_on_q[i] || pend_off_q[i])) begin
        done = 1'b1;
        ev_valid_d = 1'b1;
        ev_d.code = 6'(i);
        ev_d.on = pend_on_q[i];
        ev_d.stamp = ts_q; // [RQ7]
        if (pend_on_q[i]) begin
          pend_on_d[i] = 1'b0;
        end else begin
          pend_off_d[i] = 1'b0;
        end
      end
    end
    // new edges set after the clear so none is lost
    pend_on_d = pend_on_d | ev_rise;
    pend_off_d = pend_off_d | ev_fall;
  end
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      pend_on_q <= '0;
      pend_off_q <= '0;
      event_valid_q <= 1'b0;
      event_q <= '0;
    end else begin
      pend_on_q <= pend_on_d;
      pend_off_q <= pend_off_d;
      event_valid_q <= ev_valid_d;
      event_q <= ev_d;
    end
  end
endmodule : psel_selector

// ---- verif/psel_selector_assertions.sv ----
// checker for the parameter set priority selector
`timescale 1ns/1ps
module psel_checker
  import psel_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic [7:0] param_set_request,
  input wire psel_cfg_t cfg,
  input wire logic [31:0] store_on,
  input wire logic [31:0] store_off,
  input wire logic [2:0] active_set_q,
  input wire logic [7:0] set_enabled_q,
  input wire logic event_valid_q,
  input wire psel_event_t event_q
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  logic run;
  assign run = !cfg.force_en && cfg.used_sets != 3'h0;
  reset_vals_a: assert property (
    $rose(rstn) |-> active_set_q == 3'h0 && set_enabled_q == 8'h01)
    else $error("bad reset state");
  idle_zero_a: assert property (
    (cfg.used_sets == 3'h0 && !cfg.force_en)[*3] |-> active_set_q == 3'h0)
    else $error("idle selector moved");
  top_prio_a: assert property (
    (run && param_set_request[0])[*5] |-> active_set_q == 3'h0)
    else $error("held set one lost");
  second_prio_a: assert property (
    (run && param_set_request[1:0] == 2'h2)[*5] |-> active_set_q == 3'h1)
    else $error("held set two lost");
  no_fallback_a: assert property (
    (run && param_set_request == 8'h00 && cfg.remote_set == 4'h0
      && cfg.local_set == 4'h0)[*4] |-> $stable(active_set_q))
    else $error("active set moved");
  force_pick_a: assert property (
    (cfg.force_en && cfg.force_set != 4'h0
      && cfg.force_set <= {1'b0, cfg.used_sets} + 4'h1)[*4]
    |-> active_set_q == 3'(cfg.force_set - 4'h1))
    else $error("forced set not used");
  stamp_step_a: assert property (
    event_valid_q ##1 event_valid_q
    |-> event_q.stamp == $past(event_q.stamp) + 32'h1)
    else $error("stamp not stepping");
  active_event_a: assert property (
    $changed(active_set_q) && store_on == 32'hFFFF_FFFF |-> ##[1:40]
    (event_valid_q && event_q.on && event_q.code == {3'h3, active_set_q}))
    else $error("no active event");
  off_filter_a: assert property (
    event_valid_q && !event_q.on |-> store_off[event_q.code])
    else $error("off edge not filtered");
endmodule : psel_checker
bind psel_selector psel_checker chk (.sys_clk(sys_clk), .rstn(rstn),
  .param_set_request(param_set_request), .cfg(cfg), .store_on(store_on),
  .store_off(store_off), .active_set_q(active_set_q),
  .set_enabled_q(set_enabled_q), .event_valid_q(event_valid_q),
  .event_q(event_q));

// ---- verif/psel_input_model.sv ----
// far-side model: digital inputs giving set requests as levels or pulses
`timescale 1ns/1ps
module psel_input_model (
  input wire logic sys_clk,
  input wire logic [7:0] hold,
  input wire logic [7:0] kick,
  output logic [7:0] pins
);
  logic [7:0] pulse_q = 8'h00;
  int n = 0;
  // pulses last four cycles, moved at the falling edge
  always @(negedge sys_clk)
    if (kick != 8'h00) begin
      pulse_q <= kick;
      n <= 3;
    end else if (n > 0)
      n <= n - 1;
    else
      pulse_q <= 8'h00;
  assign pins = hold | pulse_q;
endmodule : psel_input_model

// ---- verif/psel_selector_test.sv ----
// self-checking bench for the parameter set priority selector
`timescale 1ns/1ps
module psel_selector_test
  import psel_pkg::*;
;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] hold = 8'h00;
  logic [7:0] kick = 8'h00;
  logic [7:0] pins;
  psel_cfg_t cfg = '0;
  logic [2:0] active_set_q;
  logic [7:0] set_enabled_q;
  logic event_valid_q;
  psel_event_t event_q;
  logic [31:0] seen = 32'h0;
  int failures = 0;
  int n_tests = 0;
  psel_input_model far (.sys_clk(sys_clk), .hold(hold), .kick(kick),
    .pins(pins));
  psel_selector dut (.sys_clk(sys_clk), .rstn(rstn),
    .param_set_request(pins), .cfg(cfg), .store_on(32'hFFFF_FFFF),
    .store_off(32'h00FF_FFFF), .active_set_q(active_set_q),
    .set_enabled_q(set_enabled_q), .event_valid_q(event_valid_q),
    .event_q(event_q));
  initial forever #25 sys_clk = ~sys_clk;
  // records every asserting event code seen since the last clear
  always @(posedge sys_clk)
    if (event_valid_q === 1'b1 && event_q.on === 1'b1)
      seen[event_q.code[4:0]] <= 1'b1;
  task automatic check(input string what, input logic [7:0] got,
    input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : check
  task automatic wt(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : wt
  task automatic pulse(input int b);
    kick <= 8'h01 << b;
    wt(1);
    kick <= 8'h00;
    wt(12);
  endtask : pulse
  // pulse one input and look while it still stands in the selector
  task automatic peek(input int b, input logic [7:0] exp);
    kick <= 8'h01 << b;
    wt(1);
    kick <= 8'h00;
    wt(4);
    act(exp);
    wt(8);
  endtask : peek
  task automatic act(input logic [7:0] exp);
    check("active set", {5'h00, active_set_q}, exp);
  endtask : act
  task automatic ev(input int c);
    check("event", {7'h00, seen[c]}, 8'h01);
  endtask : ev
  task automatic t_idle;
    check("enabled", set_enabled_q, 8'h01);
    pulse(2);
    act(8'h00);
    $display("test idle done");
  endtask : t_idle
  task automatic t_pulse;
    cfg.used_sets = 3'h7;
    wt(4);
    check("enabled", set_enabled_q, 8'hFF);
    seen = 32'h0;
    pulse(2);
    act(8'h02);
    wt(30);
    act(8'h02);
    ev(26);
    ev(10);
    pulse(0);
    act(8'h00);
    $display("test pulse done");
  endtask : t_pulse
  task automatic t_hold;
    seen = 32'h0;
    hold <= 8'h10;
    wt(8);
    act(8'h04);
    pulse(6);
    act(8'h04);
    ev(21);
    peek(1, 8'h01);
    act(8'h04);
    hold <= 8'h01;
    wt(8);
    pulse(3);
    act(8'h00);
    hold <= 8'h02;
    wt(8);
    act(8'h01);
    hold <= 8'h80;
    wt(8);
    act(8'h07);
    peek(6, 8'h06);
    act(8'h07);
    hold <= 8'h00;
    $display("test hold done");
  endtask : t_hold
  task automatic t_other;
    pulse(1);
    cfg.used_sets = 3'h2;
    seen = 32'h0;
    pulse(6);
    act(8'h01);
    ev(19);
    cfg.remote_set = 4'h3;
    wt(8);
    act(8'h02);
    cfg.remote_set = 4'h0;
    cfg.local_set = 4'h2;
    wt(8);
    act(8'h01);
    cfg.local_set = 4'h0;
    cfg.force_set = 4'h3;
    cfg.force_en = 1'b1;
    wt(8);
    pulse(0);
    act(8'h02);
    cfg.force_set = 4'h8;
    wt(8);
    act(8'h02);
    cfg.force_en = 1'b0;
    wt(8);
    act(8'h02);
    ev(16);
    ev(17);
    ev(18);
    ev(20);
    $display("test other done");
  endtask : t_other
  task automatic conclude;
    $display("checks %0d, mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : conclude
  initial begin
    wt(12);
    rstn <= 1'b1;
    wt(4);
    t_idle();
    t_pulse();
    t_hold();
    t_other();
    conclude();
  end
  initial begin
    repeat (5000) @(posedge sys_clk);
    failures++;
    conclude();
  end
endmodule : psel_selector_test
